/* File: core/brp_pkg.sv */
package brp_pkg;
  // Sample and byte widths
  localparam int PIX_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  // Field positions inside a sample
  localparam int HI_MSB = 11;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  // Bytes carried per pixel pair
  localparam int GROUP_BYTES = 3;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [11:0] PIX_RST = 12'h000;

  // Colour of the filter element behind a pixel
  typedef enum logic [1:0] {
    BRP_GREEN,
    BRP_BLUE,
    BRP_RED
  } brp_colour_t;

  // Pixel beat from the sensor pipeline
  typedef struct packed {
    logic valid;
    logic sol;
    logic eol;
    logic [11:0] data;
  } brp_pix_t;

  // Byte beat toward the host stream
  typedef struct packed {
    logic valid;
    logic sol;
    logic eol;
    logic [1:0] colour;
    logic [7:0] data;
  } brp_byte_t;
endpackage

/* File: core/brp_packer.sv */
`timescale 1ns/1ps
// How it works
// RULE_01: Every pixel yields exactly twelve sample bits.
// RULE_02: Pixel pairs fill three bytes, no padding.
// RULE_03: Samples pass through with no processing.
// RULE_04: Byte one holds first pixel bits 11..4.
// RULE_05: Byte two mixes both pixels' low nibbles.
// RULE_06: Byte three holds second pixel bits 11..4.
// RULE_07: Even lines: green then blue alternating.
// RULE_08: Odd lines: red then green alternating.
// RULE_09: Samples are unsigned codes 0 to 4095.
// RULE_10: Packing restarts at every line start.
// RULE_11: Second low nibble high, first low nibble low.
// RULE_12: Lines hold an even pixel count.
module brp_packer (
  input wire logic clock,
  input wire logic rstn,
  input wire brp_pkg::brp_pix_t pix_in,
  output logic pix_ready,
  output brp_pkg::brp_byte_t byte_out
);

  typedef enum logic [1:0] {
    BRP_S_FIRST,
    BRP_S_SECOND,
    BRP_S_THIRD
  } brp_state_t;

  typedef struct packed {
    brp_state_t st;
    logic odd_line;
    logic [11:0] first;
    logic first_eol;
    logic [11:0] second;
    logic second_eol;
    logic ready;
    brp_pkg::brp_byte_t out;
  } brp_regs_t;

  brp_regs_t q_r;
  brp_regs_t q_nxt;

  // Colour of a pixel from line parity and position parity
  function automatic logic [1:0] brp_colour(input logic odd_line, input logic odd_pix);
    if (odd_line) begin
      brp_colour = odd_pix ? brp_pkg::BRP_GREEN : brp_pkg::BRP_RED;
    end else begin
      brp_colour = odd_pix ? brp_pkg::BRP_BLUE : brp_pkg::BRP_GREEN;
    end
  endfunction

  wire logic take = pix_in.valid && q_r.ready;

  // Pair collector and byte sequencer; pixel input stalls while the third byte goes out,
  // since a pair needs three byte slots but brings only two pixels
  always_comb begin
    q_nxt = q_r;
    q_nxt.out.valid = 1'b0;
    q_nxt.out.sol = 1'b0;
    q_nxt.out.eol = 1'b0;
    // RULE_02: three slots per pair
    unique case (q_r.st)
      BRP_S_FIRST: begin
        q_nxt.ready = 1'b1;
        if (take) begin
          // RULE_10: line restart here
          if (pix_in.sol) begin
            q_nxt.odd_line = q_r.odd_line ^ 1'b1;
          end
          // RULE_01: all twelve bits kept
          // RULE_03: raw sample kept
          // RULE_09: unsigned code, no rescale
          q_nxt.first = pix_in.data;
          q_nxt.first_eol = pix_in.eol;
          // RULE_04: high bits first
          q_nxt.out.data = pix_in.data[brp_pkg::HI_MSB:brp_pkg::HI_LSB];
          q_nxt.out.valid = 1'b1;
          q_nxt.out.sol = pix_in.sol;
          // RULE_07: even line colours
          // RULE_08: odd line colours
          q_nxt.out.colour = brp_colour(pix_in.sol ? ~q_r.odd_line : q_r.odd_line, 1'b0);
          q_nxt.st = BRP_S_SECOND;
        end
      end
      BRP_S_SECOND: begin
        q_nxt.ready = 1'b1;
        if (take) begin
          q_nxt.second = pix_in.data;
          q_nxt.second_eol = pix_in.eol;
          // RULE_05: shared nibble byte
          // RULE_11: second nibble on top
          q_nxt.out.data = {pix_in.data[brp_pkg::LO_MSB:brp_pkg::LO_LSB],
                            q_r.first[brp_pkg::LO_MSB:brp_pkg::LO_LSB]};
          q_nxt.out.valid = 1'b1;
          q_nxt.out.colour = brp_colour(q_r.odd_line, 1'b1);
          q_nxt.ready = 1'b0;
          q_nxt.st = BRP_S_THIRD;
        end
      end
      BRP_S_THIRD: begin
        // RULE_06: second pixel high bits
        q_nxt.out.data = q_r.second[brp_pkg::HI_MSB:brp_pkg::HI_LSB];
        q_nxt.out.valid = 1'b1;
        // RULE_12: line ends on a pair
        q_nxt.out.eol = q_r.second_eol;
        q_nxt.out.colour = brp_colour(q_r.odd_line, 1'b1);
        q_nxt.ready = 1'b1;
        q_nxt.st = BRP_S_FIRST;
      end
      // Unused code recovers to a group start rather than locking the input
      default: begin
        q_nxt.ready = 1'b1;
        q_nxt.st = BRP_S_FIRST;
      end
    endcase
  end

  // State register; odd_line starts set so the first line of a frame counts as line 0
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q_r.st <= BRP_S_FIRST;
      q_r.odd_line <= 1'b1;
      q_r.first <= brp_pkg::PIX_RST;
      q_r.first_eol <= 1'b0;
      q_r.second <= brp_pkg::PIX_RST;
      q_r.second_eol <= 1'b0;
      q_r.ready <= 1'b1;
      q_r.out <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pix_ready = q_r.ready;
  assign byte_out = q_r.out;

  // RULE_02: first pixel gives a byte
  a_first_byte: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    take && q_r.st == BRP_S_FIRST |=> byte_out.valid)
    else $error("first pixel gave no byte");

  // RULE_02: three bytes per pair
  a_group_three: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    take && q_r.st == BRP_S_SECOND |=> byte_out.valid ##1 byte_out.valid)
    else $error("pair did not produce three bytes");

  // RULE_02: no padding bytes
  a_no_padding: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    byte_out.valid |-> $past(take) || $past(q_r.st) == BRP_S_THIRD)
    else $error("byte sent with no pixel behind it");

  // RULE_02: stall only on third byte
  a_ready_third: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    !pix_ready |-> q_r.st == BRP_S_THIRD)
    else $error("input stalled outside the third byte");

  // RULE_03: raw sample kept whole
  a_raw_kept: assert property (@(posedge clock) disable iff (!rstn) // RULE_03
    take && q_r.st == BRP_S_FIRST |=> q_r.first == $past(pix_in.data))
    else $error("held sample differs from input");

  // RULE_04: first byte high bits
  a_first_high: assert property (@(posedge clock) disable iff (!rstn) // RULE_04
    take && q_r.st == BRP_S_FIRST
    |=> byte_out.data == $past(pix_in.data[brp_pkg::HI_MSB:brp_pkg::HI_LSB]))
    else $error("first byte mismatch");

  // RULE_05: middle byte mixes nibbles
  a_mid_nibbles: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
    take && q_r.st == BRP_S_SECOND
    |=> byte_out.data == {$past(pix_in.data[brp_pkg::LO_MSB:brp_pkg::LO_LSB]),
                          $past(q_r.first[brp_pkg::LO_MSB:brp_pkg::LO_LSB])})
    else $error("middle byte mismatch");

  // RULE_06: third byte second high bits
  a_third_high: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
    take && q_r.st == BRP_S_SECOND
    |=> ##1 byte_out.valid
    && byte_out.data == $past(pix_in.data[brp_pkg::HI_MSB:brp_pkg::HI_LSB], 2))
    else $error("third byte mismatch");

  // RULE_06: last two bytes share colour
  a_pair_colour: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
    byte_out.valid && $past(q_r.st) == BRP_S_SECOND
    |=> byte_out.colour == $past(byte_out.colour))
    else $error("third byte colour differs from middle byte");

  // RULE_07: even line starts green
  a_even_green: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
    byte_out.valid && byte_out.sol && !q_r.odd_line
    |-> byte_out.colour == brp_pkg::BRP_GREEN)
    else $error("even line must start green");

  // RULE_08: odd line starts red
  a_odd_red: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
    byte_out.valid && byte_out.sol && q_r.odd_line
    |-> byte_out.colour == brp_pkg::BRP_RED)
    else $error("odd line must start red");

  // RULE_07 RULE_08: even position colours
  a_even_colour: assert property (@(posedge clock) disable iff (!rstn) // RULE_07 RULE_08
    byte_out.valid && $past(q_r.st) == BRP_S_FIRST
    |-> byte_out.colour == (q_r.odd_line ? brp_pkg::BRP_RED : brp_pkg::BRP_GREEN))
    else $error("even position colour wrong");

  // RULE_07 RULE_08: odd position colours
  a_odd_colour: assert property (@(posedge clock) disable iff (!rstn) // RULE_07 RULE_08
    byte_out.valid && $past(q_r.st) != BRP_S_FIRST
    |-> byte_out.colour == (q_r.odd_line ? brp_pkg::BRP_GREEN : brp_pkg::BRP_BLUE))
    else $error("odd position colour wrong");

  // RULE_10: line start opens group
  a_line_restart: assert property (@(posedge clock) disable iff (!rstn) // RULE_10
    byte_out.valid && byte_out.sol |-> $past(q_r.st) == BRP_S_FIRST)
    else $error("line start not at group start");

  // RULE_12: line end on third byte
  a_eol_third: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
    byte_out.valid && byte_out.eol |-> $past(q_r.st) == BRP_S_THIRD)
    else $error("line end not on group end");

  // RULE_12: start and end apart
  a_sol_not_eol: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
    byte_out.valid && byte_out.sol |-> !byte_out.eol)
    else $error("line start and end on one byte");

  // RULE_01: one stall per pair
  a_stall_after: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
    take && q_r.st == BRP_S_SECOND |=> !pix_ready ##1 pix_ready)
    else $error("stall pattern wrong");

endmodule

/* File: sim/brp_host_model.sv */
`timescale 1ns/1ps
// Host image buffer: records every byte beat as {sol, eol, colour, data}
module brp_host_model (
  input wire logic clock,
  input wire brp_pkg::brp_byte_t byte_in
);
  logic [11:0] buf_q[$];
  always @(posedge clock) begin
    if (byte_in.valid === 1'b1) begin
      buf_q.push_back({byte_in.sol, byte_in.eol, byte_in.colour, byte_in.data});
    end
  end
endmodule

/* File: sim/tb_bayer_raw12_packer.sv */
`timescale 1ns/1ps
module tb_bayer_raw12_packer;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  brp_pkg::brp_pix_t pix = '0;
  logic pix_ready;
  brp_pkg::brp_byte_t byte_out;
  int num_errors = 0;
  int n_tests = 0;
  brp_packer i_dut (.clock(clock), .rstn(rstn), .pix_in(pix), .pix_ready(pix_ready),
    .byte_out(byte_out));
  brp_host_model i_host (.clock(clock), .byte_in(byte_out));
  // 25 MHz clock
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Offers a pixel and holds it through the stall after each pair
  task automatic put(input logic [11:0] v, input logic s, input logic e);
    int k;
    k = 0;
    @(negedge clock);
    pix = '{1'b1, s, e, v};
    while (pix_ready !== 1'b1 && k < 8) begin
      @(negedge clock);
      k++;
    end
    chk_flag(pix_ready, 1'b1);
    @(posedge clock);
  endtask
  // One four-pixel line sent back to back, then every byte judged
  task automatic run_line(input bit odd, input logic [11:0] p0, p1, p2, p3);
    logic [11:0] p[4];
    logic [11:0] q[$];
    logic [1:0] ce;
    logic [1:0] co;
    int j;
    p = '{p0, p1, p2, p3};
    ce = odd ? brp_pkg::BRP_RED : brp_pkg::BRP_GREEN;
    co = odd ? brp_pkg::BRP_GREEN : brp_pkg::BRP_BLUE;
    i_host.buf_q.delete();
    for (j = 0; j < 4; j++) put(p[j], j == 0, j == 3);
    @(negedge clock);
    pix = '0;
    repeat (4) @(negedge clock);
    q = i_host.buf_q;
    chk(12'(q.size()), 12'h006);
    if (q.size() < 6) return;
    for (j = 0; j < 2; j++) begin
      chk(q[3*j], {j == 0, 1'b0, ce, p[2*j][11:4]});
      chk(q[3*j+1], {2'b00, co, p[2*j+1][3:0], p[2*j][3:0]});
      chk(q[3*j+2], {1'b0, j == 1, co, p[2*j+1][11:4]});
    end
  endtask
  // Mid-run reset, then one pair with idle gaps; parity must restart at even
  task automatic run_gap_reset(input logic [11:0] p0, input logic [11:0] p1);
    logic [11:0] q[$];
    @(negedge clock);
    rstn = 1'b0;
    @(negedge clock);
    chk_flag(pix_ready, 1'b1);
    chk_flag(byte_out.valid, 1'b0);
    rstn = 1'b1;
    i_host.buf_q.delete();
    put(p0, 1'b1, 1'b0);
    @(negedge clock);
    pix = '0;
    repeat (2) @(negedge clock);
    put(p1, 1'b0, 1'b1);
    @(negedge clock);
    pix = '0;
    chk_flag(pix_ready, 1'b0);
    @(negedge clock);
    chk_flag(pix_ready, 1'b1);
    repeat (2) @(negedge clock);
    q = i_host.buf_q;
    chk(12'(q.size()), 12'h003);
    if (q.size() < 3) return;
    chk(q[0], {2'b10, 2'(brp_pkg::BRP_GREEN), p0[11:4]});
    chk(q[1], {2'b00, 2'(brp_pkg::BRP_BLUE), p1[3:0], p0[3:0]});
    chk(q[2], {2'b01, 2'(brp_pkg::BRP_BLUE), p1[11:4]});
  endtask
  // Reset for 8 cycles, then even, odd and even lines again
  initial begin
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    run_line(1'b0, 12'h000, 12'hFFF, 12'hA5C, 12'h3C7);
    run_line(1'b1, 12'h123, 12'h456, 12'h789, 12'hABC);
    run_line(1'b0, 12'hFED, 12'h001, 12'h800, 12'h7FF);
    run_gap_reset(12'hC3A, 12'h5E1);
    print_verdict();
  end
  // Watchdog: four short lines need far fewer than 2000 cycles
  initial begin
    #(40 * 2000);
    num_errors++;
    print_verdict();
  end
endmodule
